//--- core/limit_regs.sv
// Purpose: threshold, identification and serial number registers
// Assumes: serial number input is static after reset
// Notes:   read data registered; unmapped pointers read zero
`timescale 1ns/100ps
`default_nettype none

module limit_regs #(
  parameter logic [11:0] PART_ID  = 12'h5a5, // arbitrary value
  parameter logic [3:0]  REVISION = 4'h2     // arbitrary value
) (
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  input  wire logic [47:0] serial_number,
  regbus_if.bank           bus
);

  logic [11:0] low_r;
  logic [11:0] high_r;

  // low threshold, reserved bits not stored
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      low_r <= tsreg_pkg::LOW_RESET[tsreg_pkg::THR_MSB:tsreg_pkg::THR_LSB];
    end else if (bus.wr_en && bus.ptr == tsreg_pkg::PTR_LOW_THR) begin
      low_r <= bus.wr_data[tsreg_pkg::THR_MSB:tsreg_pkg::THR_LSB];
    end
  end

  // high threshold
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      high_r <= tsreg_pkg::HIGH_RESET[tsreg_pkg::THR_MSB:tsreg_pkg::THR_LSB];
    end else if (bus.wr_en && bus.ptr == tsreg_pkg::PTR_HIGH_THR) begin
      high_r <= bus.wr_data[tsreg_pkg::THR_MSB:tsreg_pkg::THR_LSB];
    end
  end

  // read mux
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      bus.rd_data <= tsreg_pkg::READ_ZERO;
    end else begin
      case (bus.ptr)
        tsreg_pkg::PTR_LOW_THR:  bus.rd_data <= {low_r, tsreg_pkg::RSV_ZERO};
        tsreg_pkg::PTR_HIGH_THR: bus.rd_data <= {high_r, tsreg_pkg::RSV_ZERO};
        tsreg_pkg::PTR_PART_ID:  bus.rd_data <= {PART_ID, REVISION};
        tsreg_pkg::PTR_SN_LOW:   bus.rd_data <= serial_number[tsreg_pkg::SN_MID_LSB-1:0];
        tsreg_pkg::PTR_SN_MID:   bus.rd_data <= serial_number[tsreg_pkg::SN_HIGH_LSB-1:tsreg_pkg::SN_MID_LSB];
        tsreg_pkg::PTR_SN_HIGH:  bus.rd_data <= serial_number[tsreg_pkg::SN_W-1:tsreg_pkg::SN_HIGH_LSB];
        default:                 bus.rd_data <= tsreg_pkg::READ_ZERO;
      endcase
    end
  end

  assign bus.low_thr  = low_r;
  assign bus.high_thr = high_r;

endmodule : limit_regs

`default_nettype wire

//--- core/pin_sync.sv
// Purpose: three-stage synchroniser for asynchronous pin inputs
// Assumes: idle level of every input is high
// Notes:   output moves only when stages two and three agree
`timescale 1ns/100ps
`default_nettype none

module pin_sync #(
  parameter int W = 2
) (
  input  wire logic         ref_clk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] din,
  output var  logic [W-1:0] dout
);

  for (genvar i = 0; i < W; i++) begin : g_bit
    logic s1_r;
    logic s2_r;
    logic s3_r;
    always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
        s1_r    <= 1'b1;
        s2_r    <= 1'b1;
        s3_r    <= 1'b1;
        dout[i] <= 1'b1;
      end else begin
        s1_r <= din[i];
        s2_r <= s1_r;
        s3_r <= s2_r;
        if (s2_r == s3_r) begin
          dout[i] <= s3_r;
        end
      end
    end
  end

endmodule : pin_sync

`default_nettype wire

//--- core/regbus_if.sv
// Purpose: carries register accesses from the serial engine to the bank
// Assumes: one clock domain, write is a one-cycle strobe
// Notes:   read data follows the pointer one cycle later
`timescale 1ns/100ps
`default_nettype none

interface regbus_if;
  logic        wr_en;
  logic [7:0]  ptr;
  logic [15:0] wr_data;
  logic [15:0] rd_data;
  logic [11:0] low_thr;
  logic [11:0] high_thr;

  modport ctrl (output wr_en, output ptr, output wr_data,
                input rd_data, input low_thr, input high_thr);
  modport bank (input wr_en, input ptr, input wr_data,
                output rd_data, output low_thr, output high_thr);
endinterface : regbus_if

`default_nettype wire

//--- core/temp_sensor_limit_and_id_regs.sv
// Purpose: two-wire target giving access to limit and id registers
// Assumes: bus host drives scl, sda is open drain, no clock stretching
// Notes:   pointer byte first; data moves msb byte first
//
// Summary of operation
// - low threshold at 02h, 12-bit field 15:4
// - low threshold resets to 4b00h
// - high threshold at 03h, 12-bit field 15:4
// - high threshold resets to 5000h
// - read-only id: part 15:4, revision 3:0
// - 0ch returns serial number bits 15:0
// - 0dh returns serial number bits 31:16
// - 0eh returns serial number bits 47:32
// - access over two-wire bus, device is target
`timescale 1ns/100ps
`default_nettype none

module temp_sensor_limit_and_id_regs #(
  parameter logic [6:0]  TARGET_ADDR = 7'h48,
  parameter logic [11:0] PART_ID     = 12'h5a5, // arbitrary value
  parameter logic [3:0]  REVISION    = 4'h2     // arbitrary value
) (
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output var  logic        sda_o,
  output var  logic        sda_oe,
  input  wire logic [47:0] serial_number,
  output var  logic [11:0] low_alert_threshold,
  output var  logic [11:0] high_alert_threshold
);

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK,
    ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK
  } tgt_state_t;

  regbus_if bus ();

  tgt_state_t  state_r;
  tgt_state_t  state_nxt;
  logic [1:0]  pins_s;
  logic        scl_s;
  logic        sda_s;
  logic        scl_q;
  logic        sda_q;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_det;
  logic        stop_det;
  logic [3:0]  cnt_r;
  logic [7:0]  shift_r;
  logic [7:0]  tx_r;
  logic [7:0]  ptr_r;
  logic [7:0]  msb_r;
  logic [15:0] word_r;
  logic        rw_r;
  logic        byte_sel_r;
  logic        nack_r;
  logic        wr_en_r;
  logic [15:0] wr_data_r;
  logic        addr_match;
  logic        rx_state;
  logic        ack_state;
  logic        state_chg;

  pin_sync #(
    .W    (tsreg_pkg::SYNC_W)
  ) u_sync (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .din     ({scl_i, sda_i}),
    .dout    (pins_s)
  );

  limit_regs #(
    .PART_ID  (PART_ID),
    .REVISION (REVISION)
  ) u_regs (
    .ref_clk       (ref_clk),
    .arst_n        (arst_n),
    .serial_number (serial_number),
    .bus           (bus)
  );

  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  // bus edge and condition detection
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  assign scl_rise   = scl_s & ~scl_q;
  assign scl_fall   = ~scl_s & scl_q;
  assign start_det  = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_det   = scl_s & scl_q & ~sda_q & sda_s;
  assign addr_match = (shift_r[7:1] == TARGET_ADDR);
  assign rx_state   = (state_r == ST_ADDR) || (state_r == ST_PTR) || (state_r == ST_WDATA);
  assign ack_state  = (state_r == ST_ADDR_ACK) || (state_r == ST_PTR_ACK) || (state_r == ST_WDATA_ACK);
  assign state_chg  = (state_nxt != state_r);

  // transfer sequencing
  always_comb begin
    state_nxt = state_r;
    if (stop_det) begin
      state_nxt = ST_IDLE;
    end else if (start_det) begin
      state_nxt = ST_ADDR;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          state_nxt = ST_IDLE;
        end
        ST_ADDR: begin
          if (scl_fall && cnt_r == tsreg_pkg::BYTE_BITS) begin
            state_nxt = addr_match ? ST_ADDR_ACK : ST_IDLE;
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            state_nxt = rw_r ? ST_RDATA : ST_PTR;
          end
        end
        ST_PTR: begin
          if (scl_fall && cnt_r == tsreg_pkg::BYTE_BITS) begin
            state_nxt = ST_PTR_ACK;
          end
        end
        ST_PTR_ACK: begin
          if (scl_fall) begin
            state_nxt = ST_WDATA;
          end
        end
        ST_WDATA: begin
          if (scl_fall && cnt_r == tsreg_pkg::BYTE_BITS) begin
            state_nxt = ST_WDATA_ACK;
          end
        end
        ST_WDATA_ACK: begin
          if (scl_fall) begin
            state_nxt = ST_WDATA;
          end
        end
        ST_RDATA: begin
          if (scl_fall && cnt_r == tsreg_pkg::LAST_TX_BIT) begin
            state_nxt = ST_RDATA_ACK;
          end
        end
        ST_RDATA_ACK: begin
          if (scl_fall) begin
            state_nxt = nack_r ? ST_IDLE : ST_RDATA;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // bit counter and receive shifter
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r   <= tsreg_pkg::CNT_ZERO;
      shift_r <= 8'h00;
    end else if (start_det || state_chg) begin
      cnt_r <= tsreg_pkg::CNT_ZERO;
    end else if (rx_state && scl_rise) begin
      cnt_r   <= cnt_r + tsreg_pkg::CNT_ONE;
      shift_r <= {shift_r[6:0], sda_s};
    end else if (state_r == ST_RDATA && scl_fall) begin
      cnt_r <= cnt_r + tsreg_pkg::CNT_ONE;
    end
  end

  // direction and pointer capture
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rw_r  <= 1'b0;
      ptr_r <= tsreg_pkg::PTR_RESET;
    end else if (state_r == ST_ADDR && state_nxt == ST_ADDR_ACK) begin
      rw_r <= shift_r[0];
    end else if (state_r == ST_PTR && state_nxt == ST_PTR_ACK) begin
      ptr_r <= shift_r;
    end
  end

  // byte position within the 16-bit word
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      byte_sel_r <= 1'b0;
    end else if (state_nxt == ST_ADDR_ACK || state_nxt == ST_PTR_ACK) begin
      byte_sel_r <= 1'b0;
    end else if ((state_r == ST_WDATA_ACK || state_r == ST_RDATA_ACK) && state_nxt == ST_WDATA) begin
      byte_sel_r <= ~byte_sel_r;
    end else if (state_r == ST_RDATA_ACK && state_nxt == ST_RDATA) begin
      byte_sel_r <= ~byte_sel_r;
    end
  end

  // write assembly, commit after low byte
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      msb_r     <= 8'h00;
      wr_en_r   <= 1'b0;
      wr_data_r <= tsreg_pkg::READ_ZERO;
    end else begin
      wr_en_r <= 1'b0;
      if (state_r == ST_WDATA && state_nxt == ST_WDATA_ACK) begin
        if (!byte_sel_r) begin
          msb_r <= shift_r;
        end else begin
          wr_en_r   <= 1'b1;
          wr_data_r <= {msb_r, shift_r};
        end
      end
    end
  end

  // read shifter, word latched at start of read
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_r   <= 8'hff;
      word_r <= tsreg_pkg::READ_ZERO;
      nack_r <= 1'b1;
    end else if (state_r == ST_ADDR_ACK && state_nxt == ST_RDATA) begin
      word_r <= bus.rd_data;
      tx_r   <= bus.rd_data[15:8];
    end else if (state_r == ST_RDATA_ACK && state_nxt == ST_RDATA) begin
      tx_r <= byte_sel_r ? word_r[15:8] : word_r[7:0];
    end else if (state_r == ST_RDATA && scl_fall) begin
      tx_r <= {tx_r[6:0], 1'b1};
    end else if (state_r == ST_RDATA_ACK && scl_rise) begin
      nack_r <= sda_s;
    end
  end

  // open-drain drive: acks and zero data bits
  assign sda_o  = 1'b0;
  assign sda_oe = ack_state || (state_r == ST_RDATA && !tx_r[7]);

  assign bus.wr_en   = wr_en_r;
  assign bus.ptr     = ptr_r;
  assign bus.wr_data = wr_data_r;

  assign low_alert_threshold  = bus.low_thr;
  assign high_alert_threshold = bus.high_thr;

  // checking helpers
  logic low_written_r;
  logic high_written_r;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      low_written_r  <= 1'b0;
      high_written_r <= 1'b0;
    end else if (wr_en_r) begin
      low_written_r  <= low_written_r  | (ptr_r == tsreg_pkg::PTR_LOW_THR);
      high_written_r <= high_written_r | (ptr_r == tsreg_pkg::PTR_HIGH_THR);
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  sequence addr_done_s;
    (state_r == ST_ADDR) ##1 (state_r == ST_ADDR_ACK);
  endsequence

  sequence write_commit_s;
    wr_en_r && ptr_r == tsreg_pkg::PTR_LOW_THR;
  endsequence

  low_write_a: assert property (write_commit_s |=> low_alert_threshold == $past(wr_data_r[15:4]))
    else $error("low threshold not updated by write");
  low_reset_a: assert property ($past(ptr_r) == tsreg_pkg::PTR_LOW_THR && !$past(low_written_r)
                                |-> bus.rd_data == tsreg_pkg::LOW_RESET)
    else $error("low threshold reset value wrong");
  high_write_a: assert property (wr_en_r && ptr_r == tsreg_pkg::PTR_HIGH_THR
                                 |=> high_alert_threshold == $past(wr_data_r[15:4]))
    else $error("high threshold not updated by write");
  high_reset_a: assert property ($past(ptr_r) == tsreg_pkg::PTR_HIGH_THR && !$past(high_written_r)
                                 |-> bus.rd_data == tsreg_pkg::HIGH_RESET)
    else $error("high threshold reset value wrong");
  id_read_a: assert property ($past(ptr_r) == tsreg_pkg::PTR_PART_ID |-> bus.rd_data == {PART_ID, REVISION})
    else $error("identification register wrong");
  sn_low_a: assert property ($past(ptr_r) == tsreg_pkg::PTR_SN_LOW |-> bus.rd_data == serial_number[15:0])
    else $error("serial low word wrong");
  sn_mid_a: assert property ($past(ptr_r) == tsreg_pkg::PTR_SN_MID |-> bus.rd_data == serial_number[31:16])
    else $error("serial mid word wrong");
  sn_high_a: assert property ($past(ptr_r) == tsreg_pkg::PTR_SN_HIGH |-> bus.rd_data == serial_number[47:32])
    else $error("serial high word wrong");
  addr_ack_a: assert property (addr_done_s |-> sda_oe && !sda_o)
    else $error("address not acknowledged");
  reserved_zero_a: assert property (($past(ptr_r) == tsreg_pkg::PTR_LOW_THR || $past(ptr_r) == tsreg_pkg::PTR_HIGH_THR)
                                    |-> bus.rd_data[3:0] == tsreg_pkg::RSV_ZERO)
    else $error("reserved bits not zero");
  msb_first_a: assert property (wr_en_r |-> state_r == ST_WDATA_ACK && byte_sel_r
                                && wr_data_r[15:8] == msb_r)
    else $error("write committed before low byte");

endmodule : temp_sensor_limit_and_id_regs

`default_nettype wire

//--- core/tsreg_pkg.sv
// Purpose: shared constants for the limit and identification register bank
// Assumes: 16-bit registers selected by an 8-bit pointer byte
// Notes:   serial bus framing constants live here too
`default_nettype none

package tsreg_pkg;

  // pointer values
  localparam logic [7:0]  PTR_LOW_THR   = 8'h02;
  localparam logic [7:0]  PTR_HIGH_THR  = 8'h03;
  localparam logic [7:0]  PTR_PART_ID   = 8'h0b;
  localparam logic [7:0]  PTR_SN_LOW    = 8'h0c;
  localparam logic [7:0]  PTR_SN_MID    = 8'h0d;
  localparam logic [7:0]  PTR_SN_HIGH   = 8'h0e;
  localparam logic [7:0]  PTR_RESET     = 8'h00;

  // register layout
  localparam int          REG_W         = 16;
  localparam int          THR_MSB       = 15;
  localparam int          THR_LSB       = 4;
  localparam int          THR_W         = 12;
  localparam int          RSV_W         = 4;
  localparam int          SN_W          = 48;
  localparam int          SN_MID_LSB    = 16;
  localparam int          SN_HIGH_LSB   = 32;
  localparam logic [3:0]  RSV_ZERO      = 4'h0;

  // reset values
  localparam logic [15:0] LOW_RESET     = 16'h4b00;
  localparam logic [15:0] HIGH_RESET    = 16'h5000;
  localparam logic [15:0] READ_ZERO     = 16'h0000;

  // serial framing
  localparam logic [3:0]  BYTE_BITS     = 4'h8;
  localparam logic [3:0]  LAST_TX_BIT   = 4'h7;
  localparam logic [3:0]  CNT_ZERO      = 4'h0;
  localparam logic [3:0]  CNT_ONE       = 4'h1;
  localparam int          SYNC_W        = 2;

endpackage : tsreg_pkg

`default_nettype wire

//--- verification/bus_host_model.sv
// Purpose: two-wire bus host driving the limit and id register target
// Assumes: open-drain data line with pull-up, host owns the bus clock
// Notes:   q sets quarter bit time in ref_clk cycles, larger is slower
`timescale 1ns/100ps
`default_nettype none

module bus_host_model #(
  parameter logic [6:0] ADDR = 7'h48
) (
  input  wire logic ref_clk,
  input  wire logic sda,
  output var  logic scl,
  output var  logic host_low
);
  int q = 8;

  initial begin
    scl      = 1'b1;
    host_low = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : tick

  // start or repeated start, host is controller
  task automatic start_cond();
    tick(q);
    host_low = 1'b0;
    tick(q);
    scl = 1'b1;
    tick(q);
    host_low = 1'b1;
    tick(q);
    scl = 1'b0;
  endtask : start_cond

  task automatic stop_cond();
    tick(q);
    host_low = 1'b1;
    tick(q);
    scl = 1'b1;
    tick(q);
    host_low = 1'b0;
    tick(q);
  endtask : stop_cond

  task automatic bit_io(input logic b, output logic s);
    tick(q);
    host_low = !b;
    tick(q);
    scl = 1'b1;
    tick(q);
    s = sda;
    tick(q);
    scl = 1'b0;
  endtask : bit_io

  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
    end
    bit_io(1'b1, s);
    ack = !s;
  endtask : wbyte

  task automatic rbyte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(!ack, s);
  endtask : rbyte

  // pointer byte then msb, lsb
  task automatic write_reg(input logic [7:0] ptr, input logic [15:0] d, output logic ack);
    logic [3:0] a;
    start_cond();
    wbyte({ADDR, 1'b0}, a[0]);
    wbyte(ptr, a[1]);
    wbyte(d[15:8], a[2]);
    wbyte(d[7:0], a[3]);
    stop_cond();
    ack = &a;
  endtask : write_reg

  // pointer set, repeated start, msb then lsb
  task automatic read_reg(input logic [7:0] ptr, output logic [15:0] d);
    logic a;
    start_cond();
    wbyte({ADDR, 1'b0}, a);
    wbyte(ptr, a);
    start_cond();
    wbyte({ADDR, 1'b1}, a);
    rbyte(1'b1, d[15:8]);
    rbyte(1'b0, d[7:0]);
    stop_cond();
  endtask : read_reg
endmodule : bus_host_model

`default_nettype wire

//--- verification/tb.sv
// Purpose: self-checking bench for the limit and id register target
// Assumes: bus host model on the far side, wire resolved here
// Notes:   inputs change at falling clock edge
`timescale 1ns/100ps
`default_nettype none

module tb;
  logic        ref_clk;
  logic        arst_n;
  logic        scl;
  logic        host_low;
  logic        sda_o;
  logic        sda_oe;
  logic        sda;
  logic [47:0] serial_number;
  logic [11:0] low_alert_threshold;
  logic [11:0] high_alert_threshold;
  int          mismatches;
  int          checks;

  assign sda = (sda_oe ? sda_o : 1'b1) & !host_low;

  // part id and revision values are arbitrary
  temp_sensor_limit_and_id_regs #(
    .TARGET_ADDR (7'h48),
    .PART_ID     (12'h3c7),
    .REVISION    (4'h9)
  ) i_dut (
    .ref_clk              (ref_clk),
    .arst_n               (arst_n),
    .scl_i                (scl),
    .sda_i                (sda),
    .sda_o                (sda_o),
    .sda_oe               (sda_oe),
    .serial_number        (serial_number),
    .low_alert_threshold  (low_alert_threshold),
    .high_alert_threshold (high_alert_threshold)
  );

  bus_host_model #(.ADDR(7'h48)) i_host (
    .ref_clk  (ref_clk),
    .sda      (sda),
    .scl      (scl),
    .host_low (host_low)
  );

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = !ref_clk;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic t_reset();
    logic [15:0] d;
    i_host.read_reg(8'h02, d);
    chk("low reset", 16'h4b00, d);
    i_host.read_reg(8'h03, d);
    chk("high reset", 16'h5000, d);
    chk("low out", 16'h04b0, {4'h0, low_alert_threshold});
    chk("high out", 16'h0500, {4'h0, high_alert_threshold});
    $display("test reset values done");
  endtask : t_reset

  task automatic t_thresholds();
    logic [15:0] d;
    logic        a;
    i_host.write_reg(8'h02, 16'he70f, a);
    chk("low write ack", 16'h0001, {15'h0000, a});
    i_host.read_reg(8'h02, d);
    chk("low negative", 16'he700, d);
    chk("low out", 16'h0e70, {4'h0, low_alert_threshold});
    i_host.q = 20;
    i_host.write_reg(8'h03, 16'h8005, a);
    i_host.read_reg(8'h03, d);
    chk("high slow", 16'h8000, d);
    i_host.q = 8;
    chk("high out", 16'h0800, {4'h0, high_alert_threshold});
    i_host.read_reg(8'h02, d);
    chk("low kept", 16'he700, d);
    $display("test thresholds done");
  endtask : t_thresholds

  task automatic t_ident();
    logic [15:0] d;
    logic        a;
    i_host.write_reg(8'h0b, 16'h1234, a);
    chk("ro write ack", 16'h0001, {15'h0000, a});
    i_host.read_reg(8'h0b, d);
    chk("ident", 16'h3c79, d);
    i_host.read_reg(8'h0c, d);
    chk("serial low", 16'h1234, d);
    i_host.read_reg(8'h0d, d);
    chk("serial mid", 16'h5678, d);
    i_host.write_reg(8'h0e, 16'h0000, a);
    i_host.read_reg(8'h0e, d);
    chk("serial high", 16'h9abc, d);
    i_host.start_cond();
    i_host.wbyte({7'h48, 1'b1}, a);
    chk("read addr ack", 16'h0001, {15'h0000, a});
    i_host.rbyte(1'b1, d[15:8]);
    i_host.rbyte(1'b1, d[7:0]);
    chk("kept pointer", 16'h9abc, d);
    i_host.rbyte(1'b0, d[15:8]);
    i_host.stop_cond();
    chk("repeat msb", 16'h009a, {8'h00, d[15:8]});
    $display("test ident done");
  endtask : t_ident

  task automatic t_refuse();
    logic [15:0] d;
    logic        a;
    i_host.start_cond();
    i_host.wbyte({7'h49, 1'b0}, a);
    i_host.stop_cond();
    chk("foreign addr ack", 16'h0000, {15'h0000, a});
    i_host.start_cond();
    i_host.wbyte({7'h48, 1'b0}, a);
    i_host.wbyte(8'h02, a);
    i_host.wbyte(8'h55, a);
    i_host.stop_cond();
    i_host.read_reg(8'h02, d);
    chk("half word", 16'he700, d);
    i_host.read_reg(8'h07, d);
    chk("unmapped", 16'h0000, d);
    $display("test refusals done");
  endtask : t_refuse

  task automatic t_rereset();
    logic [15:0] d;
    @(negedge ref_clk);
    arst_n = 1'b0;
    repeat (3) @(negedge ref_clk);
    arst_n = 1'b1;
    repeat (8) @(negedge ref_clk);
    i_host.read_reg(8'h02, d);
    chk("low after reset", 16'h4b00, d);
    chk("high out after reset", 16'h0500, {4'h0, high_alert_threshold});
    $display("test second reset done");
  endtask : t_rereset

  initial begin
    repeat (90000) @(posedge ref_clk);
    mismatches++;
    $display("MISMATCH watchdog expected finish seen hang");
    conclude();
  end

  initial begin
    mismatches    = 0;
    checks        = 0;
    arst_n        = 1'b0;
    serial_number = 48'h9abc_5678_1234;
    repeat (12) @(negedge ref_clk);
    arst_n = 1'b1;
    repeat (8) @(negedge ref_clk);
    t_reset();
    t_thresholds();
    t_ident();
    t_refuse();
    t_rereset();
    conclude();
  end
endmodule : tb

`default_nettype wire
